// ==== dv/test_tile_io_port_clocking.sv ====
`timescale 1ns/1ps
`include "tiop_defines.svh"
module test_tile_io_port_clocking;
  import tiop_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, pin_in, pin_out, pin_oe_n, pin_pd;
  logic strobe_in, strobe_out, event_out, er;
  logic [4:0] clk_pin;
  logic [31:0] rd, v, c;
  int n_fail = 0;
  int check_count = 0;
  int n_evt = 0;
  int wt[5] = '{1, 4, 8, 16, 32};
  tiop_port u_dut (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
    .pin_pd, .clk_pin, .strobe_in, .strobe_out, .event_out);
  tiop_far_end u_far (.ref_clk, .pin_out, .pin_oe_n, .pin_pd, .strobe_out,
    .pin_in, .strobe_in, .clk_pin);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (event_out === 1'b1) n_evt++;
  task automatic check(input logic [31:0] seen, exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 0, "apb wait");
  endtask
  function automatic logic [31:0] mk(input logic [2:0] cs,
    input logic tm, so, si, input logic [1:0] cd, input logic [2:0] w,
    input logic od, dir);
    return {18'h00000, cs, tm, so, si, cd, w, od, dir, 1'b1};
  endfunction
  // expected chunks built lsb first from the word
  task automatic out_word(input logic [31:0] ctl, word, lost, input int w);
    logic [31:0] ch, wm, m;
    int k;
    wm = (w == 32) ? 32'hFFFFFFFF : (32'h00000001 << w) - 1;
    m = wm & ~lost;
    k = 0;
    u_far.cap_out.delete();
    u_far.cap_oe.delete();
    apb(1'b1, `TIOP_OFF_CTRL, ctl);
    apb(1'b1, `TIOP_OFF_DATA, word);
    while (u_far.cap_out.size() < 32 / w && k < 200)
    begin
      @(posedge ref_clk);
      k++;
    end
    repeat (4) @(posedge ref_clk);
    check(u_far.cap_out.size(), 32 / w, "chunk count");
    for (int i = 0; i < 32 / w; i++)
    begin
      ch = (word >> (i * w)) & wm;
      if (ctl[2])
        check(~u_far.cap_oe[i], ~ch & m, "od enables");
      else
      begin
        check(~u_far.cap_oe[i], m, "enables");
        check(u_far.cap_out[i] & m, ch & m, "chunk");
      end
    end
  endtask
  initial
  begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    void'($urandom(25113));
    repeat (3) @(posedge ref_clk);
    check(pin_pd, 32'hFFFFFFFF, "pd in reset");
    check(pin_oe_n, 32'hFFFFFFFF, "oe in reset");
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check(pin_pd, 32'h00000000, "pd after reset");
    apb(1'b0, `TIOP_OFF_CTRL, 32'h0);
    check(rd, `TIOP_CTRL_RESET, "ctrl reset");
    apb(1'b0, `TIOP_OFF_CLKCFG, 32'h0);
    check(rd, 32'h00000000, "clkcfg reset");
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1, "unmapped err");
    check(rd, 32'h00000000, "unmapped data");
    for (int i = 0; i < 5; i++)
      out_word(mk(0, 0, 1, 0, 0, i, 0, 1), $urandom(), 0, wt[i]);
    apb(1'b1, `TIOP_OFF_LINK, 32'h3);
    apb(1'b1, `TIOP_OFF_CLAIM, 32'h30);
    out_word(mk(0, 0, 1, 0, 0, 2, 0, 1), $urandom(), 32'h33, 8);
    apb(1'b1, `TIOP_OFF_LINK, 32'h0);
    apb(1'b1, `TIOP_OFF_CLAIM, 32'h0);
    out_word(mk(0, 0, 1, 0, 0, 1, 1, 1), $urandom(), 0, 4);
    v = $urandom();
    apb(1'b1, `TIOP_OFF_COND, v);
    apb(1'b1, `TIOP_OFF_CTRL, mk(0, 0, 0, 1, 1, 4, 0, 0));
    repeat (2) @(posedge ref_clk);
    check(pin_oe_n, 32'hFFFFFFFF, "input drives none");
    u_far.present(~v, 1'b1);
    n_evt = 0;
    repeat (30) @(posedge ref_clk);
    check(n_evt, 0, "condition unmet");
    u_far.present(v, 1'b0);
    repeat (20) @(posedge ref_clk);
    check(n_evt, 0, "no strobe");
    u_far.present(v, 1'b1);
    u_far.present(v, 1'b0);
    repeat (10) @(posedge ref_clk);
    check(n_evt, 1, "event");
    apb(1'b0, `TIOP_OFF_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1, "full");
    apb(1'b0, `TIOP_OFF_DATA, 32'h0);
    check(rd, v, "input word");
    apb(1'b1, `TIOP_OFF_CTRL, mk(0, 0, 0, 1, 2, 4, 0, 0));
    n_evt = 0;
    u_far.present(v, 1'b1);
    u_far.present(~v, 1'b1);
    u_far.present(~v, 1'b0);
    repeat (10) @(posedge ref_clk);
    check(n_evt, 1, "neq event");
    apb(1'b0, `TIOP_OFF_DATA, 32'h0);
    check(rd, ~v, "neq word");
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    c = rd;
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    check(rd, (c + 3) & 32'hFFFF, "count step");
    apb(1'b1, `TIOP_OFF_CTRL, mk(0, 1, 1, 0, 0, 4, 0, 1));
    u_far.cap_out.delete();
    u_far.cap_oe.delete();
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    v = (rd + 60) & 32'hFFFF;
    apb(1'b1, `TIOP_OFF_TIME, v);
    apb(1'b1, `TIOP_OFF_DATA, $urandom());
    check(u_far.cap_out.size(), 0, "held until time");
    repeat (70) @(posedge ref_clk);
    check(u_far.cap_out.size(), 1, "timed output");
    apb(1'b0, `TIOP_OFF_STAMP, 32'h0);
    check(rd, v, "timestamp");
    apb(1'b1, `TIOP_OFF_CTRL, mk(6, 0, 0, 0, 0, 4, 0, 1));
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    c = rd;
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    check(rd, c, "no seventh block");
    apb(1'b1, `TIOP_OFF_CLKCFG, 32'h3);
    apb(1'b1, `TIOP_OFF_CTRL, mk(1, 0, 0, 0, 0, 4, 0, 1));
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    c = rd;
    u_far.clk_burst(8);
    repeat (6) @(posedge ref_clk);
    apb(1'b0, `TIOP_OFF_COUNT, 32'h0);
    check(rd, (c + 4) & 32'hFFFF, "pin clock divided");
    finish_test();
  end
endmodule // test_tile_io_port_clocking

// ==== dv/tiop_far_end.sv ====
`timescale 1ns/1ps
module tiop_far_end
(
  input wire logic ref_clk, // tile clock, paces capture, stimulus and wander
  input wire logic [31:0] pin_out, // design drive value
  input wire logic [31:0] pin_oe_n, // design enables
  input wire logic [31:0] pin_pd, // design pull-downs
  input wire logic strobe_out, // design output strobe
  output logic [31:0] pin_in, // resolved pin levels
  output logic strobe_in, // strobe toward design
  output logic [4:0] clk_pin // application clocks
);
  logic [31:0] ext_val = 32'h00000000;
  logic ext_on = 1'b0;
  logic [31:0] junk = 32'h5A5A5A5A;
  logic [31:0] cap_out[$];
  logic [31:0] cap_oe[$];
  initial strobe_in = 1'b0;
  initial clk_pin = 5'h00;
  // released lines wander so a stale level cannot pass
  always @(posedge ref_clk) junk <= ~junk;
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : pin_pd[i] ? 1'b0 :
        ext_on ? ext_val[i] : junk[i];
  end
  always @(posedge ref_clk)
  begin
    if (strobe_out === 1'b1)
    begin
      cap_out.push_back(pin_out);
      cap_oe.push_back(pin_oe_n);
    end
  end
  task automatic present(input logic [31:0] v, input logic s);
    @(posedge ref_clk);
    ext_val <= v;
    ext_on <= 1'b1;
    strobe_in <= s;
  endtask
  task automatic clk_burst(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge ref_clk);
      clk_pin[0] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      clk_pin[0] <= 1'b0;
    end
  endtask
endmodule // tiop_far_end

// ==== rtl/tiop_defines.svh ====
`ifndef TIOP_DEFINES_SVH
`define TIOP_DEFINES_SVH
`define TIOP_OFF_CTRL 8'h00
`define TIOP_OFF_DATA 8'h04
`define TIOP_OFF_COND 8'h08
`define TIOP_OFF_TIME 8'h0C
`define TIOP_OFF_COUNT 8'h10
`define TIOP_OFF_STAMP 8'h14
`define TIOP_OFF_STATUS 8'h18
`define TIOP_OFF_LINK 8'h1C
`define TIOP_OFF_CLAIM 8'h20
`define TIOP_OFF_CLKCFG 8'h24
`define TIOP_OFF_LAST 8'h34
`define TIOP_CTRL_RESET 32'h00000000
`define TIOP_CTRL_WMASK 32'h00003FFF
`define TIOP_CLKCFG_RESET 9'h000
`define TIOP_NUM_CB 6
`define TIOP_CB_SRC_BIT 0
`define TIOP_CB_DIV_LSB 1
`define TIOP_CB_DIV_MSB 8
`endif

// ==== rtl/tiop_pkg.sv ====
package tiop_pkg;
  typedef enum logic [1:0] {TIOP_COND_NONE, TIOP_COND_EQ, TIOP_COND_NEQ,
    TIOP_COND_RSVD} tiop_cond_t;
  typedef enum logic [2:0] {TIOP_W1, TIOP_W4, TIOP_W8, TIOP_W16, TIOP_W32,
    TIOP_W5, TIOP_W6, TIOP_W7} tiop_width_t;
  typedef struct packed
  {
    logic [17:0] rsvd;
    logic [2:0] clk_sel;
    logic timed;
    logic stb_out;
    logic stb_in;
    tiop_cond_t cond;
    tiop_width_t width;
    logic od;
    logic dir_out;
    logic enable;
  } tiop_ctrl_t;
  typedef struct packed
  {
    logic [31:0] data;
    logic [31:0] oe_n;
  } tiop_pins_t;
endpackage

// ==== rtl/tiop_port.sv ====
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "tiop_defines.svh"
module tiop_port
(
  input wire logic ref_clk, // 20 MHz tile reference clock
  input wire logic sys_rst, // async reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [31:0] pin_in, // pin levels, async
  output logic [31:0] pin_out, // pin drive value
  output logic [31:0] pin_oe_n, // pin enable, low drives
  output logic [31:0] pin_pd, // pull-down enables
  input wire logic [4:0] clk_pin, // one-bit clock sources, blocks 1..5
  input wire logic strobe_in, // external input strobe, async
  output logic strobe_out, // output data strobe
  output logic event_out // event pulse to scheduler
);
  import tiop_pkg::*;

  tiop_ctrl_t ctrl_reg;
  logic [31:0] cond_reg;
  logic [15:0] time_reg;
  logic [31:0] link_reg;
  logic [31:0] claim_reg;
  logic [8:0] cb_cfg_reg [0:4];
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] pin_m_reg;
  logic [31:0] pin_s_reg;
  logic stb_m_reg;
  logic stb_s_reg;
  logic [4:0] cpin_m_reg;
  logic [4:0] cpin_s_reg;
  logic [4:0] cpin_d_reg;
  logic [15:0] count_reg;
  logic [15:0] stamp_reg;
  logic [31:0] sh_reg;
  logic [31:0] sh_next;
  logic [5:0] chunk_reg;
  logic [5:0] chunk_next;
  logic busy_reg;
  logic busy_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [31:0] xfer_reg;
  logic full_reg;
  logic stb_out_reg;
  logic event_reg;
  tiop_pins_t pins_reg;
  tiop_pins_t pins_next;
  logic [31:0] pd_reg;
  logic load_word;
  logic put_word;
  logic emit;
  logic [5:0] wbits;
  logic [5:0] chunks_m1;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [5:0] cb_tick;

  // apb decode
  wire logic setup = psel & ~penable;
  wire logic [7:0] adr = paddr[7:0];
  wire logic adr_ok = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0)
    && (adr <= `TIOP_OFF_LAST);
  // unmapped accesses neither write nor clear the full flag
  wire logic wr_en = psel & penable & pready_reg & pwrite & adr_ok;
  wire logic rd_en = psel & penable & pready_reg & ~pwrite & adr_ok;
  wire logic is_cb = adr >= `TIOP_OFF_CLKCFG;
  wire logic [7:0] cb_off = adr - `TIOP_OFF_CLKCFG;
  wire logic [2:0] cb_idx = cb_off[4:2];
  wire logic wr_data = wr_en && adr == `TIOP_OFF_DATA;
  wire logic rd_data = rd_en && adr == `TIOP_OFF_DATA;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~adr_ok;
      if (setup)
        prdata_reg <= adr_ok ? rd_mux : 32'h00000000;
    end
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (adr)
      `TIOP_OFF_CTRL: rd_mux = ctrl_reg;
      `TIOP_OFF_DATA: rd_mux = xfer_reg;
      `TIOP_OFF_COND: rd_mux = cond_reg;
      `TIOP_OFF_TIME: rd_mux = {16'h0000, time_reg};
      `TIOP_OFF_COUNT: rd_mux = {16'h0000, count_reg};
      `TIOP_OFF_STAMP: rd_mux = {16'h0000, stamp_reg};
      `TIOP_OFF_STATUS: rd_mux = {29'h00000000, stb_out_reg, busy_reg,
        full_reg};
      `TIOP_OFF_LINK: rd_mux = link_reg;
      `TIOP_OFF_CLAIM: rd_mux = claim_reg;
      default:
        if (is_cb)
          rd_mux = {23'h000000, cb_cfg_reg[cb_idx]};
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= `TIOP_CTRL_RESET;
      cond_reg <= 32'h00000000;
      time_reg <= 16'h0000;
      link_reg <= 32'h00000000;
      claim_reg <= 32'h00000000;
    end
    else if (wr_en)
    begin
      case (adr)
        `TIOP_OFF_CTRL: ctrl_reg <= pwdata & `TIOP_CTRL_WMASK;
        `TIOP_OFF_COND: cond_reg <= pwdata;
        `TIOP_OFF_TIME: time_reg <= pwdata[15:0];
        `TIOP_OFF_LINK: link_reg <= pwdata;
        `TIOP_OFF_CLAIM: claim_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // pin and strobe synchronisers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_m_reg <= 32'h00000000;
      pin_s_reg <= 32'h00000000;
      stb_m_reg <= 1'b0;
      stb_s_reg <= 1'b0;
      cpin_m_reg <= 5'h00;
      cpin_s_reg <= 5'h00;
      cpin_d_reg <= 5'h00;
    end
    else
    begin
      pin_m_reg <= pin_in;
      pin_s_reg <= pin_m_reg;
      stb_m_reg <= strobe_in;
      stb_s_reg <= stb_m_reg;
      cpin_m_reg <= clk_pin;
      cpin_s_reg <= cpin_m_reg;
      cpin_d_reg <= cpin_s_reg;
    end
  end

  // block 0 ticks every reference cycle
  assign cb_tick[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_cb
      logic [7:0] div_cnt_reg;
      logic tick_reg;
      wire logic [7:0] div =
        cb_cfg_reg[g][`TIOP_CB_DIV_MSB:`TIOP_CB_DIV_LSB];
      wire logic src_edge = cb_cfg_reg[g][`TIOP_CB_SRC_BIT] ?
        (cpin_s_reg[g] & ~cpin_d_reg[g]) : 1'b1;
      wire logic wrap = div_cnt_reg == div;
      always_ff @(posedge ref_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          div_cnt_reg <= 8'h00;
          tick_reg <= 1'b0;
        end
        else
        begin
          tick_reg <= src_edge & wrap;
          if (src_edge)
            div_cnt_reg <= wrap ? 8'h00 : div_cnt_reg + 8'h01;
        end
      end
      always_ff @(posedge ref_clk or posedge sys_rst)
      begin
        if (sys_rst)
          cb_cfg_reg[g] <= `TIOP_CLKCFG_RESET;
        else if (wr_en && is_cb && adr_ok && cb_idx == g)
          cb_cfg_reg[g] <= pwdata[8:0];
      end
      assign cb_tick[g+1] = tick_reg;
    end
  endgenerate

  // port runs on its clock block's ticks
  wire logic sel_ok = ctrl_reg.clk_sel < `TIOP_NUM_CB;
  wire logic port_tick = ctrl_reg.enable & sel_ok &
    cb_tick[ctrl_reg.clk_sel];

  always_comb
  begin
    unique case (ctrl_reg.width)
      TIOP_W1:
      begin
        wbits = 6'd1;
        chunks_m1 = 6'd31;
        wmask = 32'h00000001;
      end
      TIOP_W4:
      begin
        wbits = 6'd4;
        chunks_m1 = 6'd7;
        wmask = 32'h0000000F;
      end
      TIOP_W8:
      begin
        wbits = 6'd8;
        chunks_m1 = 6'd3;
        wmask = 32'h000000FF;
      end
      TIOP_W16:
      begin
        wbits = 6'd16;
        chunks_m1 = 6'd1;
        wmask = 32'h0000FFFF;
      end
      default:
      begin
        wbits = 6'd32;
        chunks_m1 = 6'd0;
        wmask = 32'hFFFFFFFF;
      end
    endcase
  end

  wire logic time_ok = ~ctrl_reg.timed | (count_reg == time_reg);
  wire logic [31:0] pins_w = pin_s_reg & wmask;
  wire logic [31:0] cond_w = cond_reg & wmask;
  wire logic cond_hit = (ctrl_reg.cond == TIOP_COND_NONE) ||
    (ctrl_reg.cond == TIOP_COND_EQ && pins_w == cond_w) ||
    (ctrl_reg.cond == TIOP_COND_NEQ && pins_w != cond_w);
  wire logic stb_ok = ~ctrl_reg.stb_in | stb_s_reg;
  wire logic [63:0] in_cat = {pins_w, sh_reg} >> wbits;
  wire logic in_step = port_tick & ~ctrl_reg.dir_out & stb_ok &
    (busy_reg | (cond_hit & time_ok));

  always_comb
  begin
    sh_next = sh_reg;
    chunk_next = chunk_reg;
    busy_next = busy_reg;
    dat_next = dat_reg;
    load_word = 1'b0;
    put_word = 1'b0;
    emit = 1'b0;
    if (port_tick && ctrl_reg.dir_out)
    begin
      if (busy_reg)
      begin
        emit = 1'b1;
        dat_next = sh_reg & wmask;
        sh_next = sh_reg >> wbits;
        busy_next = chunk_reg != 6'd0;
        chunk_next = chunk_reg - 6'd1;
      end
      else if (full_reg && time_ok)
      begin
        emit = 1'b1;
        load_word = 1'b1;
        dat_next = xfer_reg & wmask;
        sh_next = xfer_reg >> wbits;
        busy_next = chunks_m1 != 6'd0;
        chunk_next = chunks_m1 - 6'd1;
      end
    end
    else if (in_step)
    begin
      sh_next = in_cat[31:0];
      if (busy_reg)
      begin
        put_word = chunk_reg == 6'd0;
        busy_next = chunk_reg != 6'd0;
        chunk_next = chunk_reg - 6'd1;
      end
      else
      begin
        put_word = chunks_m1 == 6'd0;
        busy_next = chunks_m1 != 6'd0;
        chunk_next = chunks_m1 - 6'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh_reg <= 32'h00000000;
      chunk_reg <= 6'h00;
      busy_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      sh_reg <= sh_next;
      chunk_reg <= chunk_next;
      busy_reg <= busy_next;
      dat_reg <= dat_next;
    end
  end

  // transfer register; a new word wins over a clearing read
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xfer_reg <= 32'h00000000;
      full_reg <= 1'b0;
    end
    else if (put_word)
    begin
      xfer_reg <= sh_next;
      full_reg <= 1'b1;
    end
    else if (wr_data && ctrl_reg.dir_out)
    begin
      xfer_reg <= pwdata;
      full_reg <= 1'b1;
    end
    else if (load_word || (rd_data && !ctrl_reg.dir_out))
      full_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      count_reg <= 16'h0000;
    else if (port_tick)
      count_reg <= count_reg + 16'h0001;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      stamp_reg <= 16'h0000;
    else if (load_word || put_word)
      stamp_reg <= count_reg;
  end

  wire logic [31:0] own = wmask & ~link_reg & ~claim_reg &
    {32{ctrl_reg.enable & ctrl_reg.dir_out}};

  always_comb
  begin
    pins_next.data = ctrl_reg.od ? 32'h00000000 : dat_next;
    pins_next.oe_n = ctrl_reg.od ? ~(own & ~dat_next) : ~own;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pins_reg.data <= 32'h00000000;
      pins_reg.oe_n <= 32'hFFFFFFFF;
    end
    else
      pins_reg <= pins_next;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pd_reg <= 32'hFFFFFFFF;
    else
      pd_reg <= 32'h00000000;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stb_out_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      if (port_tick)
        stb_out_reg <= emit & ctrl_reg.stb_out;
      event_reg <= put_word;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pins_reg.data;
  assign pin_oe_n = pins_reg.oe_n;
  assign pin_pd = pd_reg;
  assign strobe_out = stb_out_reg;
  assign event_out = event_reg;

  default clocking cb_dflt @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_load;
    load_word;
  endsequence

  apb_ready_a: assert property (s_setup |=> pready && !$past(pready))
    else $error("apb access not answered in one cycle");
  counter_step_a: assert property (port_tick |=>
    count_reg == $past(count_reg) + 16'h0001)
    else $error("port counter did not step on tick");
  counter_hold_a: assert property (!port_tick |=> $stable(count_reg))
    else $error("port counter moved without tick");
  block_zero_a: assert property (ctrl_reg.enable &&
    ctrl_reg.clk_sel == 3'h0 |-> port_tick)
    else $error("block 0 did not tick every cycle");
  open_drain_a: assert property (ctrl_reg.od |=> pin_out == 32'h00000000)
    else $error("open drain drove a high level");
  input_float_a: assert property (!ctrl_reg.dir_out |=>
    pin_oe_n == 32'hFFFFFFFF)
    else $error("input port drove a pin");
  link_pins_a: assert property (1'b1 |=>
    (~pin_oe_n & $past(link_reg)) == 32'h00000000)
    else $error("port drove a link pin");
  claim_pins_a: assert property (1'b1 |=>
    (~pin_oe_n & $past(claim_reg)) == 32'h00000000)
    else $error("port drove a pin held by a narrower port");
  stamp_take_a: assert property (put_word |=>
    stamp_reg == $past(count_reg) && event_out)
    else $error("timestamp or event missing on input word");
  strobe_wait_a: assert property (port_tick && !ctrl_reg.dir_out &&
    ctrl_reg.stb_in && !stb_s_reg |=> $stable(sh_reg))
    else $error("sample taken without input strobe");
  load_strobe_a: assert property (s_load ##1 1'b1 |->
    strobe_out == $past(ctrl_reg.stb_out) && !full_reg)
    else $error("output strobe wrong after word load");
  timed_load_a: assert property (s_load |->
    !ctrl_reg.timed || count_reg == time_reg)
    else $error("timed transfer left early");
endmodule // tiop_port
